// File: screen_switch_defs.svh
// Constants of the screen switch and notify block: offsets, field positions,
// reset values and reserved screen numbers.
// Assumes it is included by its bare name by the package and the modules.
`ifndef SCREEN_SWITCH_DEFS_SVH
`define SCREEN_SWITCH_DEFS_SVH

// ==========================================================================
// Table geometry
`define SS_ENTRIES         8
`define SS_IDX_W           3

// ==========================================================================
// Register byte offsets
`define SS_OFF_CTRL        12'h000
`define SS_OFF_STATUS      12'h004
`define SS_OFF_CURRENT     12'h008
`define SS_OFF_ENABLE      12'h00C
`define SS_OFF_INPUTS      12'h010
`define SS_OFF_TABLE       12'h040

// ==========================================================================
// Field positions
`define SS_CTRL_POLL_BIT   0
`define SS_STAT_STROBE_BIT 0
`define SS_STAT_BCDERR_BIT 1
`define SS_STAT_BUSY_BIT   2

// ==========================================================================
// Reset values
`define SS_RST_POLL        1'b0
`define SS_RST_ENABLE      8'h00
`define SS_RST_SCREEN      16'h0000

// ==========================================================================
// Reserved screen numbers in BCD
`define SS_SCR_HIST_OCC    16'h1997
`define SS_SCR_HIST_FREQ   16'h1998
`define SS_SCR_HOST        16'h1999

`endif

// File: screen_switch_pkg.sv
// Types shared by the screen switch and notify block.
// Assumes the constants header is on the include path.
`include "screen_switch_defs.svh"

package screen_switch_pkg;

    // ======================================================================
    // Polling state machine, one-hot.
    typedef enum logic [2:0] {
        ST_SNAP  = 3'b001,
        ST_FETCH = 3'b010,
        ST_APPLY = 3'b100
    } poll_state_e;

    // ======================================================================
    // What kind of screen is on display.
    typedef enum logic [1:0] {
        VIEW_NORMAL    = 2'b00,
        VIEW_HIST_OCC  = 2'b01,
        VIEW_HIST_FREQ = 2'b10,
        VIEW_HOST      = 2'b11
    } view_e;

    typedef logic [15:0] bcd_word_t;
    typedef logic [31:0] entry_t;
    typedef logic [`SS_IDX_W-1:0] idx_t;

endpackage

// File: screen_table_mem.sv
// Bit memory table store: one word per entry, screen number low half,
// parent screen number high half.
// Assumes one clock; both read ports return data one edge after the address.
`timescale 1ns/1ps
`include "screen_switch_defs.svh"

module screen_table_mem
    import screen_switch_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   wr_en,
    input  wire idx_t   wr_idx,
    input  wire entry_t wr_data,
    input  wire idx_t   rd_a_idx,
    output entry_t      rd_a_data,
    input  wire idx_t   rd_b_idx,
    output entry_t      rd_b_data
);

    entry_t mem [`SS_ENTRIES];
    entry_t rd_a_q;
    entry_t rd_b_q;

    // ======================================================================
    // Storage has no reset; software must load an entry before enabling it.
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // ======================================================================
    // Registered read ports, one for the bus and one for the poller.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_a_q <= '0;
            rd_b_q <= '0;
        end else begin
            rd_a_q <= mem[rd_a_idx];
            rd_b_q <= mem[rd_b_idx];
        end
    end

    assign rd_a_data = rd_a_q;
    assign rd_b_data = rd_b_q;

endmodule

// File: screen_switch_and_notify.sv
// Screen switch and notify logic of the operator terminal, APB slave.
// Assumes switch_bits and notify_ack come from the controller's memory
// image outside the pclk domain, so each is synchronised first.
//
// What this block does
// - Keep polling every enabled switch bit, whatever screen is displayed.
// - On a 0 to 1 switch bit, display that entry's registered screen; of several rising in one pass, only the lowest entry's.
// - A 1 to 0 switch bit leaves the displayed screen unchanged.
// - Screens 1997, 1998, 1999 select occurrence history, frequency history, host.
// - After a change, write current-screen word and set the change strobe.
// - Clear the change strobe once delivery to the controller is acknowledged.
// - Screen numbers are four BCD digits in one word.
// - For continuous or overlapping screens, report the parent screen number.
`timescale 1ns/1ps
`include "screen_switch_defs.svh"

module screen_switch_and_notify
    import screen_switch_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  switch_bits,
    input  wire logic        notify_ack,
    output logic      [15:0] displayed_screen,
    output logic      [1:0]  special_view,
    output logic      [15:0] notify_screen,
    output logic             notify_strobe
);

    // ======================================================================
    // Declarations
    logic        [7:0]  sw_s1_q;
    logic        [7:0]  sw_s2_q;
    logic        [7:0]  sw_prev_q;
    logic               ack_s1_q;
    logic               ack_s2_q;
    logic               ack_prev_q;
    logic               poll_en_q;
    logic        [7:0]  entry_en_q;
    logic               bcd_err_q;
    poll_state_e        state_q;
    idx_t               idx_q;
    bcd_word_t          disp_q;
    view_e              view_q;
    bcd_word_t          notif_q;
    logic               strobe_q;
    logic        [31:0] prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic        [7:0]  rise_vec;
    entry_t             rd_a_data;
    entry_t             rd_b_data;

    // ======================================================================
    // Helpers
    function automatic idx_t lowest(input logic [7:0] v);
        idx_t r;
        r = '0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = idx_t'(i);
            end
        end
        return r;
    endfunction

    function automatic logic bcd_ok(input bcd_word_t w);
        return (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) &&
               (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
    endfunction

    // ======================================================================
    // Bus decode. Every transfer takes one wait state, so reads of the
    // table can come from the registered memory port.
    wire        access     = psel & penable;
    wire        aligned    = (paddr[1:0] == 2'b00);
    wire        hit_ctrl   = aligned & (paddr == `SS_OFF_CTRL);
    wire        hit_status = aligned & (paddr == `SS_OFF_STATUS);
    wire        hit_cur    = aligned & (paddr == `SS_OFF_CURRENT);
    wire        hit_en     = aligned & (paddr == `SS_OFF_ENABLE);
    wire        hit_in     = aligned & (paddr == `SS_OFF_INPUTS);
    wire        hit_table  = aligned & (paddr[11:5] == 7'(`SS_OFF_TABLE >> 5));
    wire        hit_any    = hit_ctrl | hit_status | hit_cur | hit_en | hit_in | hit_table;
    wire        wr_fire    = access & pready_q & pwrite & hit_any;
    wire idx_t  bus_idx    = paddr[4:2];
    wire [31:0] status_word = {29'h0, (state_q != ST_SNAP), bcd_err_q, strobe_q};
    wire [31:0] rd_word    = hit_table  ? rd_a_data :
                             hit_ctrl   ? {31'h0, poll_en_q} :
                             hit_status ? status_word :
                             hit_cur    ? {16'h0, notif_q} :
                             hit_en     ? {24'h0, entry_en_q} :
                             hit_in     ? {24'h0, sw_s2_q} : 32'h0;

    // ======================================================================
    // Poller decode. A rise is seen against the value kept at the last pass.
    genvar g;
    for (g = 0; g < `SS_ENTRIES; g++) begin : g_rise
        assign rise_vec[g] = sw_s2_q[g] & ~sw_prev_q[g] & entry_en_q[g] & poll_en_q;
    end

    wire        any_rise   = |rise_vec;
    wire        ack_rise   = ack_s2_q & ~ack_prev_q;
    wire bcd_word_t e_scr  = rd_b_data[15:0];
    wire bcd_word_t e_par  = rd_b_data[31:16];
    wire        e_valid    = bcd_ok(e_scr) & bcd_ok(e_par);
    wire        apply_ok   = (state_q == ST_APPLY) & e_valid;
    wire        apply_bad  = (state_q == ST_APPLY) & ~e_valid;
    wire bcd_word_t rep_scr = (e_par != 16'h0) ? e_par : e_scr;
    wire view_e new_view   = (e_scr == `SS_SCR_HIST_OCC)  ? VIEW_HIST_OCC :
                             (e_scr == `SS_SCR_HIST_FREQ) ? VIEW_HIST_FREQ :
                             (e_scr == `SS_SCR_HOST)      ? VIEW_HOST : VIEW_NORMAL;

    screen_table_mem u_table (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (wr_fire & hit_table),
        .wr_idx    (bus_idx),
        .wr_data   (pwdata),
        .rd_a_idx  (bus_idx),
        .rd_a_data (rd_a_data),
        .rd_b_idx  (idx_q),
        .rd_b_data (rd_b_data)
    );

    // ======================================================================
    // Two-flop synchronisers; only the second stage is looked at.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_s1_q  <= 8'h00;
            sw_s2_q  <= 8'h00;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            sw_s1_q  <= switch_bits;
            sw_s2_q  <= sw_s1_q;
            ack_s1_q <= notify_ack;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ======================================================================
    // APB answer, one wait state, error on unmapped or unaligned address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit_any;
            prdata_q  <= (access & ~pready_q & ~pwrite) ? rd_word : 32'h0;
        end
    end

    // ======================================================================
    // Software control registers; bcd error clears on write one, set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_en_q  <= `SS_RST_POLL;
            entry_en_q <= `SS_RST_ENABLE;
            bcd_err_q  <= 1'b0;
        end else begin
            if (wr_fire & hit_ctrl) begin
                poll_en_q <= pwdata[`SS_CTRL_POLL_BIT];
            end
            if (wr_fire & hit_en) begin
                entry_en_q <= pwdata[7:0];
            end
            if (apply_bad) begin
                bcd_err_q <= 1'b1;
            end else if (wr_fire & hit_status & pwdata[`SS_STAT_BCDERR_BIT]) begin
                bcd_err_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Poller. The pass snapshot runs at least every third cycle and reads every
    // entry at once, so a long table costs no latency. Edges from the same pass above
    // the chosen entry are dropped on purpose.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_SNAP;
            idx_q     <= '0;
            sw_prev_q <= 8'h00;
        end else begin
            case (state_q)
                ST_SNAP: begin
                    sw_prev_q <= sw_s2_q;
                    idx_q     <= lowest(rise_vec);
                    state_q   <= any_rise ? ST_FETCH : ST_SNAP;
                end
                ST_FETCH: begin
                    state_q <= ST_APPLY;
                end
                ST_APPLY: begin
                    state_q <= ST_SNAP;
                end
                default: begin
                    state_q <= ST_SNAP;
                end
            endcase
        end
    end

    // ======================================================================
    // Display and notify words. A new change wins over an acknowledge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_q     <= `SS_RST_SCREEN;
            view_q     <= VIEW_NORMAL;
            notif_q    <= `SS_RST_SCREEN;
            strobe_q   <= 1'b0;
            ack_prev_q <= 1'b0;
        end else begin
            ack_prev_q <= ack_s2_q;
            if (apply_ok) begin
                disp_q   <= e_scr;
                view_q   <= new_view;
                notif_q  <= rep_scr;
                strobe_q <= 1'b1;
            end else if (ack_rise) begin
                strobe_q <= 1'b0;
            end
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign displayed_screen = disp_q;
    assign special_view     = view_q;
    assign notify_screen    = notif_q;
    assign notify_strobe    = strobe_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rise_pass;
        (state_q == ST_SNAP) && any_rise;
    endsequence

    sequence s_change;
        (state_q == ST_FETCH) ##1 ((state_q == ST_APPLY) && e_valid);
    endsequence

    property p_poll_alive;
        1 |-> ##[0:2] (state_q == ST_SNAP);
    endproperty
    a_poll_alive: assert property (p_poll_alive) else $error("poll pass stalled");

    property p_rise_to_screen;
        s_rise_pass ##1 s_change |=> (disp_q == $past(e_scr)) && strobe_q;
    endproperty
    a_rise_to_screen: assert property (p_rise_to_screen) else $error("rise gave no screen");

    property p_no_rise_stable;
        (state_q == ST_SNAP) && !any_rise |=> $stable(disp_q) [*2];
    endproperty
    a_no_rise_stable: assert property (p_no_rise_stable) else $error("screen moved w/o rise");

    property p_reserved_view;
        apply_ok && (e_scr == `SS_SCR_HOST) |=> (view_q == VIEW_HOST);
    endproperty
    a_reserved_view: assert property (p_reserved_view) else $error("host screen not flagged");

    property p_notify_word;
        apply_ok && (e_par == 16'h0) |=> (notif_q == disp_q) && strobe_q;
    endproperty
    a_notify_word: assert property (p_notify_word) else $error("notify word wrong");

    property p_strobe_clear;
        ack_rise && !apply_ok |=> !strobe_q;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear) else $error("strobe not cleared");

    property p_bad_bcd;
        apply_bad |=> $stable(disp_q) && bcd_err_q;
    endproperty
    a_bad_bcd: assert property (p_bad_bcd) else $error("bad bcd was applied");

    property p_parent;
        apply_ok && (e_par != 16'h0) |=> (notif_q == $past(e_par));
    endproperty
    a_parent: assert property (p_parent) else $error("parent not reported");

    property p_lowest;
        s_rise_pass |=> ((($past(rise_vec) >> idx_q) & 8'h01) == 8'h01) &&
                        (($past(rise_vec) & ((8'h01 << idx_q) - 8'h01)) == 8'h00);
    endproperty
    a_lowest: assert property (p_lowest) else $error("not lowest entry");

    property p_apb_wait;
        psel && !penable |=> !pready_q ##1 (pready_q || !penable);
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing");

endmodule

// File: controller_model.sv
// Behavioural controller that shares memory words with the screen block.
// Assumes the bench hands it the switch bits to raise and an ack delay.
`timescale 1ns/1ps

module controller_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  req_bits,
    input  wire logic [7:0]  ack_dly,
    input  wire logic        notify_strobe,
    input  wire logic [15:0] notify_screen,
    output logic      [7:0]  switch_bits,
    output logic             notify_ack,
    output logic      [15:0] seen_screen
);
    // ======================================================================
    // Switch bits
    // A rise is held until the bench lowers it, so it is never shorter than the polling pass.
    always @(posedge pclk) begin
        switch_bits <= req_bits;
    end

    // ======================================================================
    // Notify handshake
    // The word is read at the strobe, then delivery is acknowledged after a chosen delay.
    // One process owns the handshake outputs, so each has a single driver.
    initial begin
        notify_ack  = 1'b0;
        seen_screen = 16'h0000;
        forever begin
            @(posedge pclk iff (presetn === 1'b1 && notify_strobe === 1'b1));
            seen_screen <= notify_screen;
            repeat (ack_dly) @(posedge pclk);
            notify_ack <= 1'b1;
            repeat (3) @(posedge pclk);
            notify_ack <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    end
endmodule

// File: tb.sv
// Self-checking bench for the screen switch and notify block.
// Assumes the defs header and package are compiled first.
`timescale 1ns/1ps
`include "screen_switch_defs.svh"

module tb
    import screen_switch_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, notify_ack, notify_strobe;
    logic [7:0]  switch_bits, req_bits, ack_dly;
    logic [15:0] displayed_screen, notify_screen, seen_screen;
    logic [1:0]  special_view;
    int          miscompares, checks;
    logic [31:0] tbl [8] = '{32'h0000_0002, 32'h0000_1997, 32'h0000_1998, 32'h0000_1999,
                             32'h0100_0005, 32'h0000_00A1, 32'h0000_1000, 32'h0000_0003};

    screen_switch_and_notify dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_bits(switch_bits),
        .notify_ack(notify_ack), .displayed_screen(displayed_screen),
        .special_view(special_view), .notify_screen(notify_screen),
        .notify_strobe(notify_strobe));
    controller_model ctl_u (.pclk(pclk), .presetn(presetn), .req_bits(req_bits),
        .ack_dly(ack_dly), .notify_strobe(notify_strobe), .notify_screen(notify_screen),
        .switch_bits(switch_bits), .notify_ack(notify_ack), .seen_screen(seen_screen));

    // ======================================================================
    // Clock and watchdog
    always #12.5 pclk = ~pclk;
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    // ======================================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One transfer; a free edge is left first so no signal is driven twice at once.
    // The wait has no limit of its own: only the watchdog ends a hung transfer.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_strobe(input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (notify_strobe !== lvl && n < 60);
        chk("strobe", {31'd0, notify_strobe}, {31'd0, lvl});
    endtask

    // Raise bits, check the new screen and the notify, lower them, see nothing move.
    task automatic switch_to(input logic [7:0] m, input logic [15:0] disp,
                             input logic [1:0] view, input logic [15:0] note);
        req_bits <= req_bits | m;
        wait_strobe(1'b1);
        chk("displayed", {16'd0, displayed_screen}, {16'd0, disp});
        chk("view", {30'd0, special_view}, {30'd0, view});
        chk("notify", {16'd0, notify_screen}, {16'd0, note});
        wait_strobe(1'b0);
        chk("seen", {16'd0, seen_screen}, {16'd0, note});
        req_bits <= req_bits & ~m;
        repeat (8) @(posedge pclk);
        chk("held", {16'd0, displayed_screen}, {16'd0, disp});
        chk("no strobe", {31'd0, notify_strobe}, 32'h0000_0000);
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ======================================================================
    // Test sequence
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; req_bits = 8'h00; ack_dly = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("rst disp", {16'd0, displayed_screen}, 32'h0000_0000);
        chk("rst strobe", {31'd0, notify_strobe}, 32'h0000_0000);
        apb(1'b0, `SS_OFF_CTRL, 32'h0);    chk("ctrl", rd, 32'h0000_0000);
        apb(1'b0, `SS_OFF_ENABLE, 32'h0);  chk("enable", rd, 32'h0000_0000);
        apb(1'b0, `SS_OFF_CURRENT, 32'h0); chk("current", rd, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0);         chk("unmapped", {31'd0, err}, 32'h0000_0001);
        apb(1'b1, 12'h002, 32'h0);         chk("unaligned", {31'd0, err}, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'(`SS_OFF_TABLE + 4 * i), tbl[i]);
            apb(1'b0, 12'(`SS_OFF_TABLE + 4 * i), 32'h0);
            chk("table", rd, tbl[i]);
        end
        apb(1'b1, `SS_OFF_ENABLE, 32'h0000_00FF);
        apb(1'b1, `SS_OFF_CTRL, 32'h0000_0001);
        // Plain screen, then each reserved screen in turn.
        switch_to(8'h01, 16'h0002, 2'd0, 16'h0002);
        switch_to(8'h02, 16'h1997, 2'd1, 16'h1997);
        switch_to(8'h04, 16'h1998, 2'd2, 16'h1998);
        ack_dly <= 8'h0A;
        switch_to(8'h08, 16'h1999, 2'd3, 16'h1999);
        switch_to(8'h10, 16'h0005, 2'd0, 16'h0100);
        ack_dly <= 8'h00;
        apb(1'b1, `SS_OFF_CURRENT, 32'h0000_FFFF);
        apb(1'b0, `SS_OFF_CURRENT, 32'h0);
        chk("current ro", rd, 32'h0000_0100);
        // Two rises in one pass: the lower entry wins, then polling goes on.
        switch_to(8'hC0, 16'h1000, 2'd0, 16'h1000);
        switch_to(8'h80, 16'h0003, 2'd0, 16'h0003);
        // A disabled entry is not acted upon.
        apb(1'b1, `SS_OFF_ENABLE, 32'h0000_00FE);
        req_bits <= 8'h01;
        repeat (15) @(posedge pclk);
        chk("disabled", {16'd0, displayed_screen}, 32'h0000_0003);
        apb(1'b0, `SS_OFF_INPUTS, 32'h0);
        chk("inputs", rd, 32'h0000_0001);
        req_bits <= 8'h00;
        @(posedge pclk);
        // A digit outside BCD is refused and flagged until cleared.
        req_bits <= 8'h20;
        repeat (15) @(posedge pclk);
        chk("bad bcd", {16'd0, displayed_screen}, 32'h0000_0003);
        chk("bad strobe", {31'd0, notify_strobe}, 32'h0000_0000);
        req_bits <= 8'h00;
        apb(1'b0, `SS_OFF_STATUS, 32'h0);  chk("bcd err", rd & 32'h3, 32'h0000_0002);
        apb(1'b1, `SS_OFF_STATUS, 32'h0000_0002);
        apb(1'b0, `SS_OFF_STATUS, 32'h0);  chk("bcd clr", rd & 32'h3, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
